// >>> hw/nddt_pkg.sv
package nddt_pkg;

    localparam logic [7:0] OP_SET_FEAT_ALL  = 8'hEF;
    localparam logic [7:0] OP_SET_FEAT_UNIT = 8'hD5;
    localparam logic [7:0] OP_CMD_TRAIN     = 8'h18;
    localparam logic [7:0] OP_RESET         = 8'hFF;
    localparam logic [7:0] OP_RAND_OUT      = 8'h05;
    localparam logic [7:0] FEAT_TRAIN_ADDR  = 8'h20;

    localparam int EXPLICIT_BIT = 0;
    localparam int IMPLICIT_BIT = 1;

    localparam int               CODE_W       = 6;
    localparam logic [CODE_W-1:0] CODE_RESET  = 6'h20;
    localparam logic [CODE_W-1:0] CODE_MAX    = 6'h3F;
    localparam logic [7:0]       PATTERN_SEED = 8'hA5;
    localparam int               LEN_W        = 12;
    localparam logic [LEN_W-1:0] LEN_MAX      = 12'hFFF;
    localparam int               PAGE_DEF     = 16384;
    localparam int               TOGGLE_W     = 20;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_TRAIN = 4'b0100,
        ST_HOLD  = 4'b1000
    } nddt_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] featAddr;
        logic [7:0] featData;
        logic       addrZero;
        logic       unitSel;
    } nddt_cmd_t;

    typedef struct packed {
        logic explicitEn;
        logic implicitEn;
        logic statusFail;
        logic busy;
    } nddt_status_t;

endpackage

// >>> hw/nddt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nddt_sync
    import nddt_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // The first stage is read only by the second.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// >>> hw/nddt_train_top.sv
`timescale 1ns/1ps
`default_nettype none
module nddt_train_top
    import nddt_pkg::*;
#(
    parameter int PAGE_TOGGLES = PAGE_DEF
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire nddt_cmd_t    cmd,
    input  wire logic         warmupActive,
    input  wire logic         readStrobe,
    output var  logic [7:0]   dqOut,
    output var  logic         dqOe,
    output var  logic         dqsOut,
    output var  logic         dqsOe,
    output var  nddt_status_t status,
    output var  logic [CODE_W-1:0] dutyCode
);

    generate
        if (PAGE_TOGGLES < 2 || PAGE_TOGGLES > (1 << TOGGLE_W) - 1) begin : g_bad_page
            $error("PAGE_TOGGLES out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    logic rstMeta_reg;
    logic rstSync_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The strobe pin is sampled, so its rate must stay well below the clock.
    logic strobeSync;
    logic strobePrev_reg;
    logic strobeRise;

    nddt_sync #(.W(1)) u_strobe_sync (
        .clk   (sys_clk),
        .rst_n (rstSync_reg),
        .d     (readStrobe),
        .q     (strobeSync)
    );

    assign strobeRise = strobeSync & ~strobePrev_reg;

    logic [LEN_W-1:0]   hiCnt_reg;
    logic [LEN_W-1:0]   loCnt_reg;
    logic               periodValid_reg;
    logic signed [LEN_W:0] periodDiff;

    assign periodDiff = $signed({1'b0, hiCnt_reg}) - $signed({1'b0, loCnt_reg});

    always_ff @(posedge sys_clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            strobePrev_reg  <= 1'b0;
            hiCnt_reg       <= '0;
            loCnt_reg       <= '0;
            periodValid_reg <= 1'b0;
        end else begin
            strobePrev_reg <= strobeSync;
            if (strobeRise) begin
                // The rise cycle is already high; leaving it out would bias every period low.
                hiCnt_reg       <= LEN_W'(1);
                loCnt_reg       <= '0;
                periodValid_reg <= 1'b1;
            end else if (strobeSync) begin
                if (hiCnt_reg != LEN_MAX) hiCnt_reg <= hiCnt_reg + 1'b1;
            end else begin
                if (loCnt_reg != LEN_MAX) loCnt_reg <= loCnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    nddt_state_t          state_reg;
    logic                 cmdMode_reg;
    logic                 trainArmed_reg;
    logic [TOGGLE_W-1:0]  toggleCnt_reg;
    logic signed [31:0]   accDiff_reg;
    logic signed [31:0]   accAbs;
    logic                 finish;
    logic                 pass;
    logic                 featHit;
    logic                 isReset;

    assign isReset = cmd.valid && cmd.opcode == OP_RESET;
    // EFh reaches every unit; D5h only the one that is selected.
    assign featHit = cmd.valid && cmd.featAddr == FEAT_TRAIN_ADDR &&
                     (cmd.opcode == OP_SET_FEAT_ALL ||
                      (cmd.opcode == OP_SET_FEAT_UNIT && cmd.unitSel));
    assign finish  = state_reg == ST_TRAIN && strobeRise && periodValid_reg &&
                     trainArmed_reg && toggleCnt_reg == TOGGLE_W'(PAGE_TOGGLES - 1);
    assign accAbs  = accDiff_reg < 0 ? -accDiff_reg : accDiff_reg;
    // Average imbalance of at most one clock per strobe period counts as pass.
    assign pass    = accAbs <= 32'(PAGE_TOGGLES);

    always_ff @(posedge sys_clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            state_reg   <= ST_IDLE;
            cmdMode_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd.valid && cmd.opcode == OP_CMD_TRAIN && cmd.unitSel) begin
                        state_reg   <= ST_TRAIN;
                        cmdMode_reg <= 1'b1;
                    end else if (status.explicitEn) begin
                        state_reg <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (!status.explicitEn) begin
                        state_reg <= ST_IDLE;
                    end else if (cmd.valid && cmd.opcode == OP_RAND_OUT && cmd.addrZero) begin
                        state_reg   <= ST_TRAIN;
                        cmdMode_reg <= 1'b0;
                    end
                end
                ST_TRAIN: begin
                    if (isReset) begin
                        state_reg <= ST_IDLE;
                    end else if (finish) begin
                        if (cmdMode_reg) begin
                            state_reg <= pass ? ST_IDLE : ST_HOLD;
                        end else begin
                            state_reg <= ST_ARMED;
                        end
                    end
                end
                ST_HOLD: begin
                    // A failed command training waits for a reset command.
                    if (isReset) state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            toggleCnt_reg  <= '0;
            accDiff_reg    <= '0;
            trainArmed_reg <= 1'b0;
        end else if (state_reg != ST_TRAIN) begin
            toggleCnt_reg  <= '0;
            accDiff_reg    <= '0;
            trainArmed_reg <= 1'b0;
        end else if (strobeRise) begin
            // The idle gap before the page is no strobe period, so the first rise only arms.
            trainArmed_reg <= 1'b1;
            if (periodValid_reg && trainArmed_reg) begin
                toggleCnt_reg <= toggleCnt_reg + 1'b1;
                accDiff_reg   <= accDiff_reg + 32'(periodDiff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-up value of the explicit enable is zero; only set-feature moves it.
    always_ff @(posedge sys_clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            status <= '0;
        end else begin
            if (featHit) begin
                status.explicitEn <= cmd.featData[EXPLICIT_BIT];
                status.implicitEn <= cmd.featData[IMPLICIT_BIT];
            end
            if (finish) status.statusFail <= ~pass;
            status.busy <= state_reg == ST_TRAIN;
        end
    end

    logic implicitStep;
    // Explicit training owns the code while its enable is set.
    assign implicitStep = status.implicitEn && !status.explicitEn && warmupActive &&
                          strobeRise && periodValid_reg &&
                          (periodDiff > 1 || periodDiff < -1);

    always_ff @(posedge sys_clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            dutyCode <= CODE_RESET;
        end else if ((finish && !pass && accDiff_reg > 0) ||
                     (implicitStep && periodDiff > 0)) begin
            if (dutyCode != '0) dutyCode <= dutyCode - 1'b1;
        end else if ((finish && !pass && accDiff_reg < 0) ||
                     (implicitStep && periodDiff < 0)) begin
            if (dutyCode != CODE_MAX) dutyCode <= dutyCode + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Feature training floats the pins so shared-channel units never collide.
    always_ff @(posedge sys_clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            dqOut  <= PATTERN_SEED;
            dqOe   <= 1'b0;
            dqsOut <= 1'b0;
            dqsOe  <= 1'b0;
        end else begin
            dqOe   <= state_reg == ST_TRAIN && cmdMode_reg;
            dqsOe  <= state_reg == ST_TRAIN && cmdMode_reg;
            dqsOut <= strobeSync;
            if (state_reg != ST_TRAIN) dqOut <= PATTERN_SEED;
            else if (strobeRise) dqOut <= ~dqOut;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_feat_hiz: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        state_reg == ST_TRAIN && !cmdMode_reg |=> !dqOe && !dqsOe)
        else $error("pins driven during feature training");
    a_cmd_pattern: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        state_reg == ST_TRAIN && cmdMode_reg && strobeRise && !finish && !isReset
        |=> dqOe ##1 dqOut == ~$past(dqOut, 2))
        else $error("command training pattern not driven");
    a_explicit_set: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        featHit |=> status.explicitEn == $past(cmd.featData[EXPLICIT_BIT]))
        else $error("explicit enable not written");
    a_unit_skip: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        cmd.valid && cmd.opcode == OP_SET_FEAT_UNIT && !cmd.unitSel
        |=> $stable(status.explicitEn))
        else $error("unselected unit took set-feature");
    a_explicit_prio: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        status.explicitEn && state_reg != ST_TRAIN |=> $stable(dutyCode))
        else $error("code moved while explicit enabled");
    a_implicit_upd: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        implicitStep && periodDiff > 0 && dutyCode != '0
        |=> dutyCode == $past(dutyCode) - 1'b1)
        else $error("implicit update missed");
    a_fail_flag: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        finish |=> status.statusFail == !$past(pass))
        else $error("status fail bit wrong");
    a_cmd_hold: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        state_reg == ST_HOLD && !isReset |=> state_reg == ST_HOLD)
        else $error("left hold without reset");
    a_page_end: assert property (@(posedge sys_clk) disable iff (!rstSync_reg)
        finish && !cmdMode_reg && !isReset |=> state_reg == ST_ARMED)
        else $error("feature training did not rearm");
    a_reset_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rstSync_reg) |-> !status.explicitEn ##1 !status.explicitEn)
        else $error("explicit enable set after reset");

    c_feat_pass: cover property (@(posedge sys_clk) disable iff (!rstSync_reg)
        finish && !cmdMode_reg && pass);
    c_cmd_fail: cover property (@(posedge sys_clk) disable iff (!rstSync_reg)
        state_reg == ST_HOLD ##1 isReset);
    c_implicit: cover property (@(posedge sys_clk) disable iff (!rstSync_reg)
        implicitStep);

endmodule
`default_nettype wire

// >>> testbench/nddt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nddt_host_model (
    input  wire logic go,
    input  wire logic skew,
    output var  logic readStrobe,
    output var  logic hostBusy
);
    // Each frame is ten strobe periods of 125 ns. The extra periods cover the
    // first rise, which only starts the measurement. The strobe rests low
    // between frames, as a real host leaves it. The host never looks at DQ.
    initial begin
        readStrobe = 1'b0;
        hostBusy   = 1'b0;
    end
    always @(posedge go) begin
        hostBusy = 1'b1;
        // Chip-enable high time is not tracked, so the long strobe delay always applies.
        #100.7;
        // The skewed frame keeps the normal read period and moves only the duty.
        repeat (10) begin
            readStrobe = 1'b1;
            #(skew ? 90.0 : 62.5);
            readStrobe = 1'b0;
            #(skew ? 35.0 : 62.5);
        end
        hostBusy = 1'b0;
    end
endmodule
`default_nettype wire

// >>> testbench/nand_duty_cycle_training_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nand_duty_cycle_training_tb_top;
    import nddt_pkg::*;
    logic              sysClk;
    logic              rstN;
    nddt_cmd_t         cmd;
    logic              warmupActive;
    logic              readStrobe;
    logic [7:0]        dqOut;
    logic              dqOe;
    logic              dqsOut;
    logic              dqsOe;
    nddt_status_t      status;
    logic [CODE_W-1:0] dutyCode;
    logic              go;
    logic              skew;
    logic              hostBusy;
    logic              sawOe;
    logic              sawNew;
    logic              sawDqs;
    logic [CODE_W-1:0] codeKeep;
    int                mismatches;
    int                cmp_count;

    nddt_train_top #(.PAGE_TOGGLES(8)) dut (
        .sys_clk(sysClk), .rst_n(rstN), .cmd(cmd), .warmupActive(warmupActive),
        .readStrobe(readStrobe), .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut),
        .dqsOe(dqsOe), .status(status), .dutyCode(dutyCode)
    );
    nddt_host_model host (.go(go), .skew(skew), .readStrobe(readStrobe), .hostBusy(hostBusy));

    initial begin
        sysClk = 1'b0;
        forever #2.5 sysClk = ~sysClk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sysClk);
        #1;
    endtask

    task automatic send(input logic [7:0] op, input logic [7:0] fd, input logic az,
                        input logic us);
        cmd = '{1'b1, op, FEAT_TRAIN_ADDR, fd, az, us};
        tick(1);
        cmd.valid = 1'b0;
        tick(2);
    endtask

    // Runs one strobe frame and notes whether the block drove DQ/DQS meanwhile.
    task automatic frame(input logic sk);
        int n;
        n = 0;
        skew = sk;
        go = 1'b1;
        sawOe = 1'b0;
        sawNew = 1'b0;
        sawDqs = 1'b0;
        tick(1);
        go = 1'b0;
        do begin
            tick(1);
            n++;
            sawOe = sawOe | dqOe | dqsOe;
            sawDqs = sawDqs | (dqsOe & dqsOut);
            if (dqOut !== PATTERN_SEED) sawNew = 1'b1;
        end while (hostBusy && n < 400);
        if (n >= 400) begin
            mismatches++;
            report_and_stop();
        end
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        chk(dqOut, PATTERN_SEED);
        chk({6'h00, dqOe, dqsOe}, 8'h00);
        chk({4'h0, status}, 8'h00);
        chk({2'h0, dutyCode}, {2'h0, CODE_RESET});
    endtask

    task automatic t_refusals();
        send(OP_RAND_OUT, 8'h00, 1'b1, 1'b1);
        chk(8'(status.busy), 8'h00);
        send(OP_SET_FEAT_UNIT, 8'h01, 1'b0, 1'b0);
        chk(8'(status.explicitEn), 8'h00);
    endtask

    task automatic t_feature_all_pass();
        send(OP_SET_FEAT_ALL, 8'h01, 1'b0, 1'b0);
        chk(8'(status.explicitEn), 8'h01);
        send(OP_RAND_OUT, 8'h00, 1'b0, 1'b1);
        chk(8'(status.busy), 8'h00);
        send(OP_RAND_OUT, 8'h00, 1'b1, 1'b1);
        chk(8'(status.busy), 8'h01);
        frame(1'b0);
        chk(8'(sawOe), 8'h00);
        chk(8'(status.busy), 8'h00);
        chk(8'(status.statusFail), 8'h00);
        send(OP_SET_FEAT_ALL, 8'h00, 1'b0, 1'b0);
        chk(8'(status.explicitEn), 8'h00);
    endtask

    task automatic t_feature_unit_retry();
        send(OP_SET_FEAT_UNIT, 8'h01, 1'b0, 1'b1);
        chk(8'(status.explicitEn), 8'h01);
        send(OP_RAND_OUT, 8'h00, 1'b1, 1'b1);
        frame(1'b1);
        chk(8'(status.statusFail), 8'h01);
        chk(8'(dutyCode == 6'h1F || dutyCode == 6'h21), 8'h01);
        send(OP_RAND_OUT, 8'h00, 1'b1, 1'b1);
        chk(8'(status.busy), 8'h01);
        frame(1'b0);
        chk(8'(status.statusFail), 8'h00);
        send(OP_SET_FEAT_UNIT, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic t_command_train();
        send(OP_CMD_TRAIN, 8'h00, 1'b0, 1'b1);
        chk(8'(status.busy), 8'h01);
        frame(1'b1);
        chk(8'(sawOe), 8'h01);
        chk(8'(sawNew), 8'h01);
        chk(8'(sawDqs), 8'h01);
        chk(8'(status.statusFail), 8'h01);
        send(OP_RESET, 8'h00, 1'b0, 1'b1);
        send(OP_CMD_TRAIN, 8'h00, 1'b0, 1'b1);
        chk(8'(status.busy), 8'h01);
        frame(1'b0);
        chk(8'(status.statusFail), 8'h00);
    endtask

    task automatic t_implicit();
        send(OP_SET_FEAT_ALL, 8'h02, 1'b0, 1'b0);
        chk(8'(status.implicitEn), 8'h01);
        codeKeep = dutyCode;
        warmupActive = 1'b1;
        frame(1'b1);
        chk(8'(dutyCode != codeKeep), 8'h01);
        send(OP_SET_FEAT_ALL, 8'h03, 1'b0, 1'b0);
        codeKeep = dutyCode;
        frame(1'b1);
        chk({2'h0, dutyCode}, {2'h0, codeKeep});
        warmupActive = 1'b0;
        send(OP_SET_FEAT_ALL, 8'h00, 1'b0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // A hang anywhere ends the run through the same report.
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        mismatches = 0;
        cmp_count = 0;
        rstN = 1'b0;
        cmd = '0;
        warmupActive = 1'b0;
        go = 1'b0;
        skew = 1'b0;
        tick(6);
        t_reset_values();
        rstN = 1'b1;
        // Slow-speed setup and calibration count as done before any training.
        tick(4);
        t_refusals();
        t_feature_all_pass();
        t_feature_unit_retry();
        t_command_train();
        t_implicit();
        report_and_stop();
    end
endmodule
`default_nettype wire
